// ---- dws_master.sv ----
// two-wire bus master model that drives clock and data
module dws_master (
  input wire logic i_clk,
  input wire logic i_sda,
  output logic o_scl,
  output logic o_sda
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    o_scl = 1'b1;
    o_sda = 1'b1;
  end
  task automatic step(input logic c, input logic d, input int n);
    @(posedge i_clk);
    o_scl <= c;
    o_sda <= d;
    repeat (n - 1) @(posedge i_clk);
  endtask
  // data moves mid low phase, never on a clock edge
  task automatic xfer(input logic b, output logic r);
    step(1'b0, o_sda, 2);
    step(1'b0, b, 2);
    step(1'b1, b, 4);
    @(negedge i_clk) r = i_sda;
  endtask
  // pre-steps only when the wire is not already high with clock high
  task automatic start();
    if (!(o_scl && i_sda)) begin
      step(1'b0, o_sda, 2);
      step(1'b0, 1'b1, 2);
      step(1'b1, 1'b1, 4);
    end
    step(1'b1, 1'b0, 8);
  endtask
  task automatic stop();
    step(1'b0, o_sda, 2);
    step(1'b0, 1'b0, 2);
    step(1'b1, 1'b0, 4);
    step(1'b1, 1'b1, 8);
  endtask
  task automatic xbyte(input logic [7:0] d, input logic a,
    output logic [7:0] r, output logic ra);
    for (int i = 7; i >= 0; i--) xfer(d[i], r[i]);
    xfer(a, ra);
  endtask
endmodule // dws_master

// ---- dws_pkg.sv ----
// package: constants and types for the dual wiper two-wire slave
package dws_pkg;
  localparam int WIPER_WIDTH = 6;
  localparam logic [5:0] WIPER_RESET = 6'h21; // mute position, 33 decimal
  localparam logic [5:0] WIPER_MUTE = 6'h21;
  localparam logic [5:0] WIPER_MAX = 6'h21;
  localparam logic [5:0] STEP1_LAST = 6'h0c;
  localparam logic [5:0] STEP2_LAST = 6'h18;
  // device-type code is arbitrary, not tied to any part
  localparam logic [3:0] DEVICE_TYPE_CODE = 4'ha;
  localparam int TYPE_MSB = 7;
  localparam int TYPE_LSB = 4;
  localparam int SEL_MSB = 3;
  localparam int SEL_LSB = 1;
  localparam int DIR_BIT = 0;
  localparam int CHAN_BIT = 6;
  localparam int VALUE_MSB = 5;
  localparam logic DIR_READ = 1'b1;
  localparam logic [3:0] BIT_LAST = 4'h7;
  localparam logic [3:0] BIT_RESET = 4'h0;
  localparam logic [7:0] BYTE_RESET = 8'h00;

  typedef enum logic [2:0] {
    DWS_IDLE = 3'b000,
    DWS_RECV = 3'b001,
    DWS_ACK = 3'b010,
    DWS_SEND = 3'b011,
    DWS_MACK = 3'b100,
    DWS_WAIT = 3'b101
  } dws_state_type;
endpackage

// ---- dws_slave.sv ----
// module: two-wire slave port holding two volatile wiper registers
module dws_slave (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_scl,
  input wire logic i_sda,
  input wire logic i_port_enable_n,
  input wire logic i_device_select_pin_0,
  input wire logic i_device_select_pin_1,
  input wire logic i_device_select_pin_2,
  output logic o_sda_out,
  output logic o_sda_oe,
  output logic [dws_pkg::WIPER_WIDTH-1:0] o_wiper_output_0,
  output logic [dws_pkg::WIPER_WIDTH-1:0] o_wiper_output_1,
  output logic [1:0] o_tap_step_0,
  output logic [1:0] o_tap_step_1,
  output logic o_busy
);
  import dws_pkg::*;

  typedef struct packed {
    dws_state_type state;
    logic [3:0] bit_count;
    logic [7:0] shift;
    logic first;
    logic read;
    logic chan;
    logic drive_low;
    logic busy;
    logic scl_prev;
    logic sda_prev;
    logic en_n_prev;
    logic [5:0] wiper0;
    logic [5:0] wiper1;
    logic [1:0] step0;
    logic [1:0] step1;
  } dws_regs_type;

  dws_regs_type r;
  dws_regs_type next_r;
  logic scl_s;
  logic sda_s;
  logic en_n_s;
  logic [2:0] sel_s;

  dws_sync u_sync_scl (
    .i_clk(i_clk), .i_reset(i_reset), .i_pin(i_scl), .o_level(scl_s)
  );
  dws_sync u_sync_sda (
    .i_clk(i_clk), .i_reset(i_reset), .i_pin(i_sda), .o_level(sda_s)
  );
  dws_sync u_sync_en (
    .i_clk(i_clk), .i_reset(i_reset), .i_pin(i_port_enable_n),
    .o_level(en_n_s)
  );
  // straps are static, but they still cross in from pins
  dws_sync u_sync_sel0 (
    .i_clk(i_clk), .i_reset(i_reset), .i_pin(i_device_select_pin_0),
    .o_level(sel_s[0])
  );
  dws_sync u_sync_sel1 (
    .i_clk(i_clk), .i_reset(i_reset), .i_pin(i_device_select_pin_1),
    .o_level(sel_s[1])
  );
  dws_sync u_sync_sel2 (
    .i_clk(i_clk), .i_reset(i_reset), .i_pin(i_device_select_pin_2),
    .o_level(sel_s[2])
  );

  function automatic logic [1:0] tap_step(input logic [5:0] v);
    if (v <= STEP1_LAST) begin
      tap_step = 2'h1;
    end else if (v <= STEP2_LAST) begin
      tap_step = 2'h2;
    end else if (v < WIPER_MUTE) begin
      tap_step = 2'h3;
    end else begin
      tap_step = 2'h0;
    end
  endfunction

  logic scl_rise;
  logic scl_fall;
  logic start_cond;
  logic stop_cond;
  logic [2:0] sel_pins;
  logic [7:0] rx_byte;

  always_comb begin
    scl_rise = scl_s & ~r.scl_prev;
    scl_fall = ~scl_s & r.scl_prev;
    start_cond = scl_s & r.scl_prev & r.sda_prev & ~sda_s;
    stop_cond = scl_s & r.scl_prev & ~r.sda_prev & sda_s;
    sel_pins = sel_s;
    rx_byte = {r.shift[6:0], sda_s};
  end

  always_comb begin
    next_r = r;
    next_r.scl_prev = scl_s;
    next_r.sda_prev = sda_s;
    next_r.en_n_prev = en_n_s;
    next_r.step0 = tap_step(r.wiper0);
    next_r.step1 = tap_step(r.wiper1);
    if (en_n_s) begin
      next_r.state = DWS_IDLE;
      next_r.drive_low = 1'b0;
      next_r.busy = 1'b0;
    end else if (r.en_n_prev) begin
      // lines only just enabled: take a fresh edge history first
      next_r.state = DWS_IDLE;
    end else if (start_cond) begin
      // repeated start restarts decode without ending the occupancy
      next_r.state = DWS_RECV;
      next_r.bit_count = BIT_RESET;
      next_r.shift = BYTE_RESET;
      next_r.first = 1'b1;
      next_r.drive_low = 1'b0;
      next_r.busy = 1'b1;
    end else if (stop_cond) begin
      next_r.state = DWS_IDLE;
      next_r.drive_low = 1'b0;
      next_r.busy = 1'b0;
    end else begin
      case (r.state)
        DWS_IDLE: begin
          next_r.drive_low = 1'b0;
        end
        DWS_RECV: begin
          if (scl_rise) begin
            next_r.shift = rx_byte;
            next_r.bit_count = r.bit_count + 4'h1;
            if (r.bit_count == BIT_LAST) begin
              if (r.first) begin
                if (rx_byte[TYPE_MSB:TYPE_LSB] == DEVICE_TYPE_CODE &&
                    rx_byte[SEL_MSB:SEL_LSB] == sel_pins) begin
                  next_r.state = DWS_ACK;
                  next_r.read = (rx_byte[DIR_BIT] == DIR_READ);
                  next_r.chan = 1'b0;
                end else begin
                  next_r.state = DWS_WAIT;
                end
              end else begin
                if (rx_byte[CHAN_BIT]) begin
                  next_r.wiper1 = (rx_byte[VALUE_MSB:0] > WIPER_MAX) ?
                    WIPER_MAX : rx_byte[VALUE_MSB:0];
                end else begin
                  next_r.wiper0 = (rx_byte[VALUE_MSB:0] > WIPER_MAX) ?
                    WIPER_MAX : rx_byte[VALUE_MSB:0];
                end
                next_r.state = DWS_ACK;
              end
            end
          end
        end
        DWS_ACK: begin
          // pull low on the falling edge ending bit 8, hold through high
          if (scl_fall && !r.drive_low) begin
            next_r.drive_low = 1'b1;
          end else if (scl_fall && r.drive_low) begin
            next_r.bit_count = BIT_RESET;
            if (r.first && r.read) begin
              next_r.state = DWS_SEND;
              next_r.shift = {2'b00, r.wiper0};
              next_r.chan = 1'b1;
              next_r.drive_low = 1'b1; // top bit of a wiper byte is 0
            end else begin
              next_r.state = DWS_RECV;
              next_r.drive_low = 1'b0;
            end
            next_r.first = 1'b0;
          end
        end
        DWS_SEND: begin
          if (scl_fall) begin
            next_r.bit_count = r.bit_count + 4'h1;
            if (r.bit_count == BIT_LAST) begin
              next_r.state = DWS_MACK;
              next_r.drive_low = 1'b0;
            end else begin
              next_r.shift = {r.shift[6:0], 1'b0};
              next_r.drive_low = ~r.shift[6];
            end
          end
        end
        DWS_MACK: begin
          if (scl_rise) begin
            if (sda_s || !r.chan) begin
              // nack or both bytes sent: stay released until a stop or a new start
              next_r.state = DWS_WAIT;
            end else begin
              // master acked: arm the second byte for the next fall
              next_r.bit_count = BIT_RESET;
            end
          end else if (scl_fall && r.bit_count == BIT_RESET) begin
            // loading on the fall keeps bit 7 in its own low phase
            next_r.state = DWS_SEND;
            next_r.shift = {2'b00, r.wiper1};
            next_r.chan = 1'b0;
            next_r.drive_low = 1'b1;
          end
        end
        DWS_WAIT: begin
          next_r.drive_low = 1'b0;
        end
        default: begin
          next_r.state = DWS_IDLE;
          next_r.drive_low = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      r.state <= DWS_IDLE;
      r.bit_count <= BIT_RESET;
      r.shift <= BYTE_RESET;
      r.first <= 1'b0;
      r.read <= 1'b0;
      r.chan <= 1'b0;
      r.drive_low <= 1'b0;
      r.busy <= 1'b0;
      r.scl_prev <= 1'b1;
      r.sda_prev <= 1'b1;
      r.en_n_prev <= 1'b1;
      r.wiper0 <= WIPER_RESET;
      r.wiper1 <= WIPER_RESET;
      r.step0 <= 2'h0;
      r.step1 <= 2'h0;
    end else begin
      r <= next_r;
    end
  end

  always_comb begin
    o_sda_out = 1'b0;
    o_sda_oe = r.drive_low;
    o_wiper_output_0 = r.wiper0;
    o_wiper_output_1 = r.wiper1;
    o_tap_step_0 = r.step0;
    o_tap_step_1 = r.step1;
    o_busy = r.busy;
  end
endmodule // dws_slave

// ---- dws_slave_props.sv ----
// checker for the dual wiper two-wire slave ports
module dws_slave_props (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_scl,
  input wire logic i_sda,
  input wire logic i_port_enable_n,
  input wire logic i_device_select_pin_0,
  input wire logic i_device_select_pin_1,
  input wire logic i_device_select_pin_2,
  input wire logic o_sda_out,
  input wire logic o_sda_oe,
  input wire logic [dws_pkg::WIPER_WIDTH-1:0] o_wiper_output_0,
  input wire logic [dws_pkg::WIPER_WIDTH-1:0] o_wiper_output_1,
  input wire logic [1:0] o_tap_step_0,
  input wire logic [1:0] o_tap_step_1,
  input wire logic o_busy
);
  import dws_pkg::*;
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_reset);
  function automatic logic [1:0] st(input logic [5:0] w);
    return (w == WIPER_MUTE) ? 2'h0 : (w <= STEP1_LAST) ? 2'h1 :
      (w <= STEP2_LAST) ? 2'h2 : 2'h3;
  endfunction
  drive_low_a: assert property (
    o_sda_oe |-> o_busy && !o_sda_out)
    else $error("sda driven outside a transfer");
  oe_in_low_a: assert property (
    $changed(o_sda_oe) |-> !$past(i_scl, 2))
    else $error("sda enable moved in clock high");
  port_off_a: assert property (
    i_port_enable_n && $past(i_port_enable_n, 4) |-> !o_sda_oe && !o_busy)
    else $error("port active while disabled");
  busy_rise_a: assert property ($rose(o_busy) |-> i_scl && !i_sda)
    else $error("busy without start");
  busy_fall_a: assert property ($fell(o_busy) |-> i_scl && i_sda)
    else $error("busy ended without stop");
  wiper_hold_a: assert property (
    $changed(o_wiper_output_0) || $changed(o_wiper_output_1) |-> o_busy)
    else $error("wiper changed outside transfer");
  tap_zero_a: assert property (
    o_tap_step_0 == st($past(o_wiper_output_0)))
    else $error("tap step 0 wrong");
  tap_one_a: assert property (
    o_tap_step_1 == st($past(o_wiper_output_1)))
    else $error("tap step 1 wrong");
  write_c: cover property ($changed(o_wiper_output_1));
  ack_c: cover property ($rose(o_sda_oe));
  stop_c: cover property ($fell(o_busy));
endmodule // dws_slave_props
bind dws_slave dws_slave_props props (.*);

// ---- dws_slave_tb.sv ----
// testbench for the dual wiper two-wire slave
module dws_slave_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import dws_pkg::*;
  localparam logic [7:0] WR = {DEVICE_TYPE_CODE, 3'b101, 1'b0};
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic en_n = 1'b0;
  logic [2:0] sel = 3'b101;
  wire logic scl, m_sda, sda;
  logic oe, so, busy;
  logic [5:0] w0, w1;
  logic [1:0] t0, t1;
  int fails = 0;
  int check_count = 0;
  // open drain wire with pull-up
  assign sda = m_sda & ~oe;
  always #12.5 clk = ~clk;
  dws_master m (.i_clk(clk), .i_sda(sda), .o_scl(scl), .o_sda(m_sda));
  dws_slave dut (.i_clk(clk), .i_reset(rst), .i_scl(scl), .i_sda(sda),
    .i_port_enable_n(en_n), .i_device_select_pin_0(sel[0]),
    .i_device_select_pin_1(sel[1]), .i_device_select_pin_2(sel[2]),
    .o_sda_out(so), .o_sda_oe(oe), .o_wiper_output_0(w0),
    .o_wiper_output_1(w1), .o_tap_step_0(t0), .o_tap_step_1(t1),
    .o_busy(busy));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wb(input logic [7:0] d, input logic ea);
    logic [7:0] r;
    logic a;
    m.xbyte(d, 1'b1, r, a);
    chk({15'h0, a}, {15'h0, ea});
  endtask
  task automatic rb(input logic [7:0] e, input logic ma);
    logic [7:0] r;
    logic a;
    m.xbyte(8'hff, ma, r, a);
    chk({8'h0, r}, {8'h0, e});
  endtask
  task automatic summarize();
    $display("checks=%0d fails=%0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    chk({4'h0, w1, w0}, 16'h0861);
    chk({12'h0, t1, t0}, 16'h0000);
    chk({15'h0, so}, 16'h0000);
    $display("test reset done");
    m.start();
    chk({15'h0, busy}, 16'h0001);
    wb(WR, 1'b0);
    wb(8'h54, 1'b0);
    wb(8'h0c, 1'b0);
    m.stop();
    chk({15'h0, busy}, 16'h0000);
    chk({4'h0, w1, w0}, 16'h050c);
    chk({12'h0, t1, t0}, 16'h0009);
    $display("test write done");
    m.start();
    wb(WR | 8'h01, 1'b0);
    rb(8'h0c, 1'b0);
    rb(8'h14, 1'b1);
    chk({15'h0, oe}, 16'h0000);
    m.start();
    wb(WR, 1'b0);
    wb(8'h3f, 1'b0);
    wb(8'h5e, 1'b0);
    m.stop();
    chk({4'h0, w1, w0}, 16'h07a1);
    chk({12'h0, t1, t0}, 16'h000c);
    $display("test read done");
    sel <= 3'b010;
    m.start();
    wb(WR, 1'b1);
    wb(8'h41, 1'b1);
    m.stop();
    sel <= 3'b101;
    m.start();
    wb(WR ^ 8'hf0, 1'b1);
    m.stop();
    chk({4'h0, w1, w0}, 16'h07a1);
    $display("test mismatch done");
    en_n <= 1'b1;
    m.start();
    wb(WR, 1'b1);
    wb(8'h41, 1'b1);
    m.stop();
    chk({4'h0, w1, w0}, 16'h07a1);
    $display("test disable done");
    summarize();
  end
  initial begin
    repeat (30000) @(posedge clk);
    fails++;
    summarize();
  end
endmodule // dws_slave_tb

// ---- dws_sync.sv ----
// module: two flip-flop synchroniser for one pin input
module dws_sync (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_pin,
  output logic o_level
);
  logic meta;
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      meta <= 1'b1;
      o_level <= 1'b1;
    end else begin
      meta <= i_pin;
      o_level <= meta;
    end
  end
endmodule // dws_sync
